// ---- tmr_pkg.sv ----
package tmr_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_T0_PRESCALE_EDGE = 32'hFFFF_F206;
  localparam logic [31:0] ADDR_T0_PRESCALE_EXT  = 32'hFFFF_F207;
  localparam logic [31:0] ADDR_T0_OUT_CTRL      = 32'hFFFF_F20E;
  localparam logic [31:0] ADDR_T1_PRESCALE_EDGE = 32'hFFFF_F216;
  localparam logic [31:0] ADDR_T1_PRESCALE_EXT  = 32'hFFFF_F217;
  localparam logic [31:0] ADDR_T1_OUT_CTRL      = 32'hFFFF_F21E;

  // reset values
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [7:0] OUT_CTRL_RESET = 8'h00;

  // output control field positions
  localparam int OC_SOFT_TRIG   = 6;
  localparam int OC_SINGLE_MODE = 5;
  localparam int OC_SECOND_TOG  = 4;
  localparam int OC_FORCE_SET   = 3;
  localparam int OC_FORCE_CLEAR = 2;
  localparam int OC_FIRST_TOG   = 1;
  localparam int OC_OUT_EN      = 0;

  // prescale/edge field positions
  localparam int PE_PIN_B_EDGE_LO = 6;
  localparam int PE_PIN_A_EDGE_LO = 4;
  localparam int PE_CLK_SEL_LO    = 0;
  localparam int PX_CLK_SEL_HI    = 0;

  // valid edge codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // count clock source kinds
  typedef enum logic [2:0] {
    SRC_DIV, SRC_WATCH, SRC_PIN_EDGE, SRC_NONE
  } tmr_src_e;

  // prescaler width and divider exponents
  localparam int PRESCALE_BITS = 8;
  localparam int DIV_EXP_2   = 1;
  localparam int DIV_EXP_4   = 2;
  localparam int DIV_EXP_16  = 4;
  localparam int DIV_EXP_32  = 5;
  localparam int DIV_EXP_64  = 6;
  localparam int DIV_EXP_128 = 7;
  localparam int DIV_EXP_256 = 8;

  // signals from the counter core of one timer
  typedef struct packed {
    logic run;
    logic matchFirst;
    logic matchSecond;
  } tmr_core_in_s;

  // signals to the counter core of one timer
  typedef struct packed {
    logic countTick;
    logic edgeA;
    logic edgeB;
    logic singleStart;
  } tmr_core_out_s;

endpackage

// ---- tmr_edge_filter.sv ----
`timescale 1ns/1ps
module tmr_edge_filter (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // pin and control
  input  wire logic       pinAsync,
  input  wire logic       sampleEn,
  input  wire logic       run,
  input  wire logic [1:0] edgeSel,
  // result
  output logic            edgeOut,
  output logic            levelOut
);

  logic sync1_q;
  logic sync2_q;
  logic sample_q;
  logic filt_q;
  logic accepted_q;
  logic everRun_q;
  logic edgeOut_q;
  logic rise;
  logic fall;
  logic hit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pinAsync;
      sync2_q <= sync1_q;
    end
  end

  // a new level is taken only after two equal samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_q <= 1'b0;
      filt_q   <= 1'b0;
    end else if (sampleEn) begin
      sample_q <= sync2_q;
      if (sync2_q == sample_q) begin
        filt_q <= sync2_q;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      everRun_q <= 1'b0;
    end else if (run) begin
      everRun_q <= 1'b1;
    end
  end

  // accepted level starts low, so a pin high since reset shows as rising once enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accepted_q <= 1'b0;
    end else if (run || everRun_q) begin
      accepted_q <= filt_q;
    end
  end

  assign rise = filt_q & ~accepted_q;
  assign fall = ~filt_q & accepted_q;

  always_comb begin
    case (edgeSel)
      tmr_pkg::EDGE_FALL: hit = fall;
      tmr_pkg::EDGE_RISE: hit = rise;
      tmr_pkg::EDGE_BOTH: hit = rise | fall;
      default:            hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edgeOut_q <= 1'b0;
    end else begin
      edgeOut_q <= run & hit;
    end
  end

  assign edgeOut  = edgeOut_q;
  assign levelOut = filt_q;

endmodule // tmr_edge_filter

// ---- tmr_out_ff.sv ----
`timescale 1ns/1ps
module tmr_out_ff (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // events
  input  wire logic forceSet,
  input  wire logic forceClear,
  input  wire logic toggleFirst,
  input  wire logic toggleSecond,
  input  wire logic outEn,
  // result
  output logic      ffState,
  output logic      pinOut
);

  logic ff_q;
  logic ff_d;
  logic pin_q;

  always_comb begin
    ff_d = ff_q;
    if (forceSet && !forceClear) begin
      ff_d = 1'b1;
    end else if (forceClear && !forceSet) begin
      ff_d = 1'b0;
    end else if (!forceSet && !forceClear) begin
      ff_d = ff_q ^ toggleFirst ^ toggleSecond;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ff_q <= 1'b0;
    end else begin
      ff_q <= ff_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= outEn ? ff_d : 1'b0;
    end
  end

  assign ffState = ff_q;
  assign pinOut  = pin_q;

endmodule // tmr_out_ff

// ---- tmr_output_prescale_ctrl.sv ----
// Operation
// - output control: bit6 soft trigger, 5 single mode, 4/1 toggles, 3 set, 2 clear, 0 enable.
// - single mode bit 0 gives successive pulses, 1 gives one pulse per trigger.
// - second toggle enable inverts output flip-flop on second compare match.
// - first toggle enable inverts output flip-flop on first compare match.
// - set/clear pair forces flip-flop; software never writes both as one.
// - output enable low holds pin at 0, high lets it follow flip-flop.
// - single pulse works with free-running counter and with pin-A clear-and-start.
// - force set and clear act at write only and read back zero.
// - soft trigger clears itself and always reads zero.
// - reset clears all prescale registers of both timers.
// - edge field: 00 falling, 01 rising, 11 both, 10 prohibited; B at 7:6, A at 5:4.
// - timer 0 clock select: /2, /16, watch tick, pin A, /4, /64, /256.
// - timer 1 clock select: /2, /4, /16, pin A, /32, /128, /256.
// - select high bit is extension register bit 0, low bits are 1:0.
// - pin high after reset gives immediate rising edge; re-enable after stop does not.
// - pins sampled at count clock (at half rate when pin A is the count clock), two equal samples needed before accepting level.
`timescale 1ns/1ps
module tmr_output_prescale_ctrl (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // byte register port
  input  wire logic [31:0]                  regAddr,
  input  wire logic                         regWrEn,
  input  wire logic [7:0]                   regWrData,
  input  wire logic                         regRdEn,
  output logic      [7:0]                   regRdData,
  // counter core side
  input  wire tmr_pkg::tmr_core_in_s  [1:0] coreIn,
  output tmr_pkg::tmr_core_out_s      [1:0] coreOut,
  input  wire logic                         watchTick,
  // timer pins
  input  wire logic [1:0]                   pinA,
  input  wire logic [1:0]                   pinB,
  output logic      [1:0]                   timerPinOut
);

  localparam int NT = 2;

  // tick of a power-of-two divider taken from the shared prescaler
  function automatic logic divTick(input logic [tmr_pkg::PRESCALE_BITS-1:0] cnt, input int exp);
    logic [tmr_pkg::PRESCALE_BITS-1:0] mask;
    mask = '0;
    for (int i = 0; i < tmr_pkg::PRESCALE_BITS; i++) begin
      if (i < exp) begin
        mask[i] = 1'b1;
      end
    end
    return (cnt & mask) == mask;
  endfunction

  // count source kind for a three-bit select
  function automatic tmr_pkg::tmr_src_e srcKind(input logic timer1, input logic [2:0] sel);
    tmr_pkg::tmr_src_e k;
    k = tmr_pkg::SRC_DIV;
    case (sel)
      3'h2:    k = timer1 ? tmr_pkg::SRC_DIV : tmr_pkg::SRC_WATCH;
      3'h3:    k = tmr_pkg::SRC_PIN_EDGE;
      3'h7:    k = tmr_pkg::SRC_NONE;
      default: k = tmr_pkg::SRC_DIV;
    endcase
    return k;
  endfunction

  // divider exponent for a three-bit select
  function automatic int divExp(input logic timer1, input logic [2:0] sel);
    int e;
    e = tmr_pkg::DIV_EXP_2;
    if (!timer1) begin
      case (sel)
        3'h0:    e = tmr_pkg::DIV_EXP_2;
        3'h1:    e = tmr_pkg::DIV_EXP_16;
        3'h4:    e = tmr_pkg::DIV_EXP_4;
        3'h5:    e = tmr_pkg::DIV_EXP_64;
        3'h6:    e = tmr_pkg::DIV_EXP_256;
        default: e = tmr_pkg::DIV_EXP_2;
      endcase
    end else begin
      case (sel)
        3'h0:    e = tmr_pkg::DIV_EXP_2;
        3'h1:    e = tmr_pkg::DIV_EXP_4;
        3'h2:    e = tmr_pkg::DIV_EXP_16;
        3'h4:    e = tmr_pkg::DIV_EXP_32;
        3'h5:    e = tmr_pkg::DIV_EXP_128;
        3'h6:    e = tmr_pkg::DIV_EXP_256;
        default: e = tmr_pkg::DIV_EXP_2;
      endcase
    end
    return e;
  endfunction

  // registers
  logic [NT-1:0][7:0] prescaleEdge_q;
  logic [NT-1:0]      clkSelHi_q;
  logic [NT-1:0][7:0] outCtrl_q;
  logic [NT-1:0]      softTrig;
  logic [NT-1:0]      forceSet;
  logic [NT-1:0]      forceClear;
  logic [NT-1:0]      wrPrescaleEdge;
  logic [NT-1:0]      wrPrescaleExt;
  logic [NT-1:0]      wrOutCtrl;
  logic [7:0]         rdData_q;
  logic [7:0]         rdData_d;

  // shared prescaler
  logic [tmr_pkg::PRESCALE_BITS-1:0] prescale_q;
  logic                              halfRateTick;

  // per-timer state
  logic [NT-1:0] armed_q;
  logic [NT-1:0] countTick;
  logic [NT-1:0] sampleEn;
  logic [NT-1:0] edgeA;
  logic [NT-1:0] edgeB;
  logic [NT-1:0] trigger;
  logic [NT-1:0] allowToggle;
  logic [NT-1:0] singleStart_q;

  // address decode
  always_comb begin
    wrPrescaleEdge = '0;
    wrPrescaleExt  = '0;
    wrOutCtrl      = '0;
    if (regWrEn) begin
      if (regAddr == tmr_pkg::ADDR_T0_PRESCALE_EDGE) begin
        wrPrescaleEdge[0] = 1'b1;
      end else if (regAddr == tmr_pkg::ADDR_T0_PRESCALE_EXT) begin
        wrPrescaleExt[0] = 1'b1;
      end else if (regAddr == tmr_pkg::ADDR_T0_OUT_CTRL) begin
        wrOutCtrl[0] = 1'b1;
      end else if (regAddr == tmr_pkg::ADDR_T1_PRESCALE_EDGE) begin
        wrPrescaleEdge[1] = 1'b1;
      end else if (regAddr == tmr_pkg::ADDR_T1_PRESCALE_EXT) begin
        wrPrescaleExt[1] = 1'b1;
      end else if (regAddr == tmr_pkg::ADDR_T1_OUT_CTRL) begin
        wrOutCtrl[1] = 1'b1;
      end
    end
  end

  // prescale registers, whole-byte writes; bits 3:2 stay zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescaleEdge_q <= {NT{tmr_pkg::PRESCALE_RESET}};
    end else begin
      for (int t = 0; t < NT; t++) begin
        if (wrPrescaleEdge[t]) begin
          prescaleEdge_q[t] <= regWrData & 8'hF3;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkSelHi_q <= '0;
    end else begin
      for (int t = 0; t < NT; t++) begin
        if (wrPrescaleExt[t]) begin
          clkSelHi_q[t] <= regWrData[tmr_pkg::PX_CLK_SEL_HI];
        end
      end
    end
  end

  // output control: only the level bits are stored, the action bits are write pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outCtrl_q <= {NT{tmr_pkg::OUT_CTRL_RESET}};
    end else begin
      for (int t = 0; t < NT; t++) begin
        if (wrOutCtrl[t]) begin
          outCtrl_q[t] <= 8'h00;
          outCtrl_q[t][tmr_pkg::OC_SINGLE_MODE] <= regWrData[tmr_pkg::OC_SINGLE_MODE];
          outCtrl_q[t][tmr_pkg::OC_SECOND_TOG]  <= regWrData[tmr_pkg::OC_SECOND_TOG];
          outCtrl_q[t][tmr_pkg::OC_FIRST_TOG]   <= regWrData[tmr_pkg::OC_FIRST_TOG];
          outCtrl_q[t][tmr_pkg::OC_OUT_EN]      <= regWrData[tmr_pkg::OC_OUT_EN];
        end
      end
    end
  end

  always_comb begin
    for (int t = 0; t < NT; t++) begin
      softTrig[t]   = wrOutCtrl[t] & regWrData[tmr_pkg::OC_SOFT_TRIG];
      forceSet[t]   = wrOutCtrl[t] & regWrData[tmr_pkg::OC_FORCE_SET];
      forceClear[t] = wrOutCtrl[t] & regWrData[tmr_pkg::OC_FORCE_CLEAR];
    end
  end

  // read mux, answered on the edge after the read strobe
  always_comb begin
    rdData_d = 8'h00;
    if (regAddr == tmr_pkg::ADDR_T0_PRESCALE_EDGE) begin
      rdData_d = prescaleEdge_q[0];
    end else if (regAddr == tmr_pkg::ADDR_T0_PRESCALE_EXT) begin
      rdData_d = {7'h00, clkSelHi_q[0]};
    end else if (regAddr == tmr_pkg::ADDR_T0_OUT_CTRL) begin
      rdData_d = outCtrl_q[0];
    end else if (regAddr == tmr_pkg::ADDR_T1_PRESCALE_EDGE) begin
      rdData_d = prescaleEdge_q[1];
    end else if (regAddr == tmr_pkg::ADDR_T1_PRESCALE_EXT) begin
      rdData_d = {7'h00, clkSelHi_q[1]};
    end else if (regAddr == tmr_pkg::ADDR_T1_OUT_CTRL) begin
      rdData_d = outCtrl_q[1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else if (regRdEn) begin
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  // free-running prescaler shared by both timers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_q + 1'b1;
    end
  end

  assign halfRateTick = divTick(prescale_q, tmr_pkg::DIV_EXP_2);

  // count clock selection and pin sampling rate
  always_comb begin
    for (int t = 0; t < NT; t++) begin
      logic [2:0]        sel;
      tmr_pkg::tmr_src_e kind;
      sel  = {clkSelHi_q[t], prescaleEdge_q[t][tmr_pkg::PE_CLK_SEL_LO +: 2]};
      kind = srcKind(t == 1, sel);
      countTick[t] = 1'b0;
      sampleEn[t]  = 1'b0;
      case (kind)
        tmr_pkg::SRC_DIV: begin
          countTick[t] = divTick(prescale_q, divExp(t == 1, sel));
          sampleEn[t]  = countTick[t];
        end
        tmr_pkg::SRC_WATCH: begin
          countTick[t] = watchTick;
          sampleEn[t]  = watchTick;
        end
        tmr_pkg::SRC_PIN_EDGE: begin
          // the pin cannot sample itself, so it is sampled at the half rate
          countTick[t] = edgeA[t];
          sampleEn[t]  = halfRateTick;
        end
        default: begin
          countTick[t] = 1'b0;
          sampleEn[t]  = 1'b0;
        end
      endcase
    end
  end

  // per-timer edge filters and output flip-flops
  for (genvar g = 0; g < NT; g++) begin : g_timer
    tmr_edge_filter u_edge_a (
      .clk      (clk),
      .rst      (rst),
      .pinAsync (pinA[g]),
      .sampleEn (sampleEn[g]),
      .run      (coreIn[g].run),
      .edgeSel  (prescaleEdge_q[g][tmr_pkg::PE_PIN_A_EDGE_LO +: 2]),
      .edgeOut  (edgeA[g]),
      .levelOut ()
    );

    tmr_edge_filter u_edge_b (
      .clk      (clk),
      .rst      (rst),
      .pinAsync (pinB[g]),
      .sampleEn (sampleEn[g]),
      .run      (coreIn[g].run),
      .edgeSel  (prescaleEdge_q[g][tmr_pkg::PE_PIN_B_EDGE_LO +: 2]),
      .edgeOut  (edgeB[g]),
      .levelOut ()
    );

    tmr_out_ff u_out (
      .clk          (clk),
      .rst          (rst),
      .forceSet     (forceSet[g]),
      .forceClear   (forceClear[g]),
      .toggleFirst  (coreIn[g].matchFirst & outCtrl_q[g][tmr_pkg::OC_FIRST_TOG] & allowToggle[g]),
      .toggleSecond (coreIn[g].matchSecond & outCtrl_q[g][tmr_pkg::OC_SECOND_TOG] & allowToggle[g]),
      .outEn        (wrOutCtrl[g] ? regWrData[tmr_pkg::OC_OUT_EN] : outCtrl_q[g][tmr_pkg::OC_OUT_EN]),
      .ffState      (),
      .pinOut       (timerPinOut[g])
    );
  end

  // single pulse: a trigger arms the timer, the first-compare match ends the pulse
  always_comb begin
    for (int t = 0; t < NT; t++) begin
      // a soft trigger counts when its own write also selects single mode
      trigger[t]     = (softTrig[t] & regWrData[tmr_pkg::OC_SINGLE_MODE])
                     | (outCtrl_q[t][tmr_pkg::OC_SINGLE_MODE] & edgeA[t]);
      allowToggle[t] = ~outCtrl_q[t][tmr_pkg::OC_SINGLE_MODE] | armed_q[t];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q <= '0;
    end else begin
      for (int t = 0; t < NT; t++) begin
        if (trigger[t]) begin
          armed_q[t] <= 1'b1;
        end else if (armed_q[t] && coreIn[t].matchFirst) begin
          armed_q[t] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      singleStart_q <= '0;
    end else begin
      singleStart_q <= trigger;
    end
  end

  always_comb begin
    for (int t = 0; t < NT; t++) begin
      coreOut[t].countTick   = countTick[t];
      coreOut[t].edgeA       = edgeA[t];
      coreOut[t].edgeB       = edgeB[t];
      coreOut[t].singleStart = singleStart_q[t];
    end
  end

endmodule // tmr_output_prescale_ctrl

// ---- tmr_ctrl_assertions.sv ----
`timescale 1ns/1ps
module tmr_ctrl_assertions (
  // clock and reset
  input wire logic                         clk,
  input wire logic                         rst,
  // register port
  input wire logic [31:0]                  regAddr,
  input wire logic                         regWrEn,
  input wire logic [7:0]                   regWrData,
  input wire logic                         regRdEn,
  input wire logic [7:0]                   regRdData,
  // core side and pins
  input wire tmr_pkg::tmr_core_in_s  [1:0] coreIn,
  input wire tmr_pkg::tmr_core_out_s [1:0] coreOut,
  input wire logic                         watchTick,
  input wire logic [1:0]                   pinA,
  input wire logic [1:0]                   pinB,
  input wire logic [1:0]                   timerPinOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic ctrlWr;
  logic ctrlRd;
  logic noMatch;
  assign ctrlWr  = regWrEn && regAddr == tmr_pkg::ADDR_T0_OUT_CTRL;
  assign ctrlRd  = regRdEn && (regAddr == tmr_pkg::ADDR_T0_OUT_CTRL || regAddr == tmr_pkg::ADDR_T1_OUT_CTRL);
  assign noMatch = !coreIn[0].matchFirst && !coreIn[0].matchSecond;

  a_force_set_pin: assert property (
    ctrlWr && noMatch && regWrData[3:2] == 2'h2 && regWrData[0] |=> timerPinOut[0])
    else $error("force set did not raise the pin");
  a_force_clr_pin: assert property (
    ctrlWr && noMatch && regWrData[3:2] == 2'h1 |=> !timerPinOut[0])
    else $error("force clear did not lower the pin");
  a_out_disabled: assert property (
    ctrlWr && !regWrData[0] |=> !timerPinOut[0])
    else $error("disabled output not held low");
  a_pin_hold: assert property (
    !regWrEn && noMatch |=> $stable(timerPinOut[0]))
    else $error("pin changed without a cause");
  a_rd_ctrl_zero: assert property (
    ctrlRd |=> regRdData[7:6] == 2'h0 && regRdData[3:2] == 2'h0)
    else $error("self clearing control bits read nonzero");
  a_rd_ext_mask: assert property (
    regRdEn && regAddr == tmr_pkg::ADDR_T0_PRESCALE_EXT |=> regRdData[7:1] == 7'h00)
    else $error("extension register upper bits nonzero");
  a_rd_edge_mask: assert property (
    regRdEn && regAddr == tmr_pkg::ADDR_T1_PRESCALE_EDGE |=> regRdData[3:2] == 2'h0)
    else $error("edge register bits 3 and 2 nonzero");
  a_edge_single: assert property (
    coreOut[0].edgeA |=> !coreOut[0].edgeA)
    else $error("edge pulse longer than one cycle");
  a_stopped_no_edge: assert property (
    !coreIn[0].run [*3] |=> !coreOut[0].edgeA)
    else $error("edge reported while stopped");
  a_trig_start: assert property (
    ctrlWr && regWrData[6:5] == 2'h3 |-> ##[1:2] coreOut[0].singleStart)
    else $error("software trigger gave no start pulse");

  c_match_toggle: cover property (coreIn[0].matchFirst ##1 $changed(timerPinOut[0]));
  c_edge_seen: cover property (coreOut[0].edgeA);
  c_single_start: cover property (coreOut[0].singleStart);
endmodule // tmr_ctrl_assertions

// ---- tmr_pin_model.sv ----
`timescale 1ns/1ps
module tmr_pin_model (
  // clock
  input wire logic       clk,
  // timer pins
  output logic     [1:0] pinA,
  output logic     [1:0] pinB,
  input wire logic [1:0] timerPinOut
);
  initial begin
    pinA = 2'h0;
    pinB = 2'h0;
  end

  // callers hold a level well over two half-rate ticks except for a deliberate glitch
  // a pin chosen as count clock is never also used as trigger here
  task automatic drive(input int t, input int b, input logic v, input int n);
    @(posedge clk);
    #1;
    if (b == 0) pinA[t] = v;
    else pinB[t] = v;
    repeat (n - 1) @(posedge clk);
  endtask
endmodule // tmr_pin_model

// ---- tb_timer_output_and_prescaler_ctrl.sv ----
`timescale 1ns/1ps
module tb_timer_output_and_prescaler_ctrl;
  logic                         clk       = 1'h0;
  logic                         rst       = 1'h1;
  logic [31:0]                  regAddr   = 32'h0000_0000;
  logic                         regWrEn   = 1'h0;
  logic [7:0]                   regWrData = 8'h00;
  logic                         regRdEn   = 1'h0;
  logic [7:0]                   regRdData;
  tmr_pkg::tmr_core_in_s  [1:0] coreIn    = '0;
  tmr_pkg::tmr_core_out_s [1:0] coreOut;
  logic                         watchTick = 1'h0;
  logic [1:0]                   pinA;
  logic [1:0]                   pinB;
  logic [1:0]                   timerPinOut;
  logic [7:0]                   rv;
  logic [7:0]                   v;
  logic                         runOn     = 1'h0;
  int n_errors = 0, n_checks = 0, seed = 10, wdiv = 0, ssCnt = 0, ffModel = 0, ex = 0;
  int tickCnt[2];
  int edgeCnt[2][2];
  int divs[2][8] = '{'{2, 16, 0, 0, 4, 64, 256, 0}, '{2, 4, 16, 0, 32, 128, 256, 0}};
  logic [31:0] addrs[7] = '{tmr_pkg::ADDR_T0_PRESCALE_EDGE, tmr_pkg::ADDR_T0_PRESCALE_EXT,
    tmr_pkg::ADDR_T1_PRESCALE_EDGE, tmr_pkg::ADDR_T1_PRESCALE_EXT, tmr_pkg::ADDR_T0_OUT_CTRL,
    tmr_pkg::ADDR_T1_OUT_CTRL, 32'hFFFF_F208};

  always #5 clk = ~clk;

  tmr_output_prescale_ctrl dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .coreIn(coreIn),
    .coreOut(coreOut), .watchTick(watchTick), .pinA(pinA), .pinB(pinB), .timerPinOut(timerPinOut));
  tmr_pin_model pins (.clk(clk), .pinA(pinA), .pinB(pinB), .timerPinOut(timerPinOut));

  // watch tick every eighth cycle, counters of design pulses
  always @(posedge clk) begin
    wdiv = wdiv + 1;
    watchTick <= #1 (wdiv % 8 == 0);
    for (int t = 0; t < 2; t++) begin
      if (coreOut[t].countTick === 1'h1) tickCnt[t]++;
      if (coreOut[t].edgeA === 1'h1) edgeCnt[t][0]++;
      if (coreOut[t].edgeB === 1'h1) edgeCnt[t][1]++;
    end
    if (coreOut[0].singleStart === 1'h1) ssCnt++;
  end

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // timers are stopped around every register write
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'h1;
    coreIn[0].run = 1'h0;
    coreIn[1].run = 1'h0;
    step();
    regWrEn = 1'h0;
    step();
    coreIn[0].run = runOn;
    coreIn[1].run = runOn;
  endtask
  task automatic rd(input logic [31:0] a, output logic [7:0] d);
    regAddr = a;
    regRdEn = 1'h1;
    step();
    regRdEn = 1'h0;
    d = regRdData;
    step();
  endtask
  task automatic match(input int t, input int second);
    if (second != 0) coreIn[t].matchSecond = 1'h1;
    else coreIn[t].matchFirst = 1'h1;
    step();
    coreIn[t].matchFirst = 1'h0;
    coreIn[t].matchSecond = 1'h0;
    step();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // the tests need about 20000 cycles
  initial begin
    #500_000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'h0;
    step();
    foreach (addrs[i]) begin
      rd(addrs[i], rv);
      chk("reset value", rv, 8'h00);
    end
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      wr(addrs[i % 4], v);
      rd(addrs[i % 4], rv);
      chk("prescale readback", rv, v & ((i % 2) ? 8'h01 : 8'hF3));
    end
    for (int t = 0; t < 2; t++) begin
      v = ($random(seed) & 8'h33) | 8'h04;
      wr(addrs[4 + t], v);
      rd(addrs[4 + t], rv);
      chk("control readback", rv, v & 8'h33);
      chk("pin after clear", timerPinOut[t], 1'h0);
    end
    $display("test register access done");
    for (int t = 0; t < 2; t++) begin
      for (int e = 0; e < 4; e++) begin
        wr(addrs[4 + t], 8'h09 | ((e & 2) << 3) | ((e & 1) << 1));
        ffModel = 1;
        chk("pin after set", timerPinOut[t], ffModel[0]);
        match(t, 0);
        if (e & 1) ffModel ^= 1;
        chk("pin first match", timerPinOut[t], ffModel[0]);
        match(t, 1);
        if (e & 2) ffModel ^= 1;
        chk("pin second match", timerPinOut[t], ffModel[0]);
      end
      wr(addrs[4 + t], 8'h08);
      chk("pin disabled", timerPinOut[t], 1'h0);
      wr(addrs[4 + t], 8'h01);
      chk("pin enabled", timerPinOut[t], 1'h1);
    end
    $display("test output flip-flop done");
    wr(tmr_pkg::ADDR_T0_OUT_CTRL, 8'h2B);
    match(0, 0);
    chk("single unarmed", timerPinOut[0], 1'h1);
    ssCnt = 0;
    wr(tmr_pkg::ADDR_T0_OUT_CTRL, 8'h63);
    chk("start pulses", ssCnt[15:0], 16'h0001);
    rd(tmr_pkg::ADDR_T0_OUT_CTRL, rv);
    chk("trigger readback", rv, 8'h23);
    match(0, 0);
    chk("single armed", timerPinOut[0], 1'h0);
    match(0, 0);
    chk("single spent", timerPinOut[0], 1'h0);
    $display("test single pulse done");
    runOn = 1'h1;
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 8; c++) begin
        wr(addrs[2 * t + 1], 8'(c >> 2));
        wr(addrs[2 * t], 8'(c & 3));
        step(4);
        tickCnt[t] = 0;
        step(1024);
        ex = divs[t][c] ? 1024 / divs[t][c] : ((t == 0 && c == 2) ? 128 : 0);
        chk("count ticks", tickCnt[t][15:0], ex[15:0]);
      end
      wr(addrs[2 * t + 1], 8'h00);
    end
    $display("test count clock done");
    for (int t = 0; t < 2; t++) begin
      for (int b = 0; b < 2; b++) begin
        for (int e = 0; e < 4; e++) begin
          wr(addrs[2 * t], 8'(e << (b ? 6 : 4)));
          step(8);
          edgeCnt[t][b] = 0;
          pins.drive(t, b, 1'h1, 1);
          pins.drive(t, b, 1'h0, 12);
          pins.drive(t, b, 1'h1, 12);
          pins.drive(t, b, 1'h0, 12);
          step(12);
          ex = (e == 3) ? 2 : ((e == 2) ? 0 : 1);
          chk("valid edges", edgeCnt[t][b][15:0], ex[15:0]);
        end
      end
    end
    wr(tmr_pkg::ADDR_T0_PRESCALE_EDGE, 8'h10);
    step(8);
    edgeCnt[0][0] = 0;
    coreIn[0].run = 1'h0;
    pins.drive(0, 0, 1'h1, 12);
    coreIn[0].run = 1'h1;
    step(12);
    chk("edge after restart", edgeCnt[0][0][15:0], 16'h0000);
    pins.drive(0, 0, 1'h0, 12);
    runOn = 1'h0;
    coreIn[0].run = 1'h0;
    rst = 1'h1;
    pins.drive(0, 0, 1'h1, 2);
    step();
    rst = 1'h0;
    wr(tmr_pkg::ADDR_T0_PRESCALE_EDGE, 8'h10);
    step(12);
    edgeCnt[0][0] = 0;
    coreIn[0].run = 1'h1;
    step(4);
    chk("edge after reset", edgeCnt[0][0][15:0], 16'h0001);
    $display("test input edges done");
    tally_and_finish();
  end
endmodule // tb_timer_output_and_prescaler_ctrl

bind tmr_output_prescale_ctrl tmr_ctrl_assertions u_chk (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .coreIn(coreIn),
  .coreOut(coreOut), .watchTick(watchTick), .pinA(pinA), .pinB(pinB), .timerPinOut(timerPinOut));
